// >>> hdl/lpddr_init_cfg.svh
// Timing counts, mode register addresses and reset values
`ifndef LPDDR_INIT_CFG_SVH
`define LPDDR_INIT_CFG_SVH

`define CLK_PERIOD_NS 20

// Least times round up, longest times round down
`define T_INIT3_NS 200000
`define T_INIT3_CYC ((`T_INIT3_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_INIT4_NS 1000
`define T_INIT4_CYC ((`T_INIT4_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_INIT5_NS 10000
`define T_INIT5_CYC (`T_INIT5_NS / `CLK_PERIOD_NS)
`define T_ZQINIT_NS 1000
`define T_ZQINIT_CYC ((`T_ZQINIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Internal auto-init duration, must stay within the longest time
`define AUTO_INIT_DEF_CYC 400

`define MA_DEV_INFO 8'h00
`define MA_IMP_CAL 8'h0A
`define MA_RESET 8'h3F
`define OP_ZQ_INIT 8'hFF

`define MR0_DAI_BIT 0
`define MR0_RZQ_BIT 3
`define DAI_RST 1'b1
`define MR_STORE_DEPTH 16

`endif

// >>> hdl/lpddr_init_pkg.sv
// Types for the power-up sequencing block
package lpddr_init_pkg;

    typedef enum logic [7:0] {
        ST_OFF       = 8'h01,
        ST_NOP       = 8'h02,
        ST_WAIT_RST  = 8'h04,
        ST_RST_WAIT  = 8'h08,
        ST_AUTO_INIT = 8'h10,
        ST_IDLE      = 8'h20,
        ST_ZQ        = 8'h40,
        ST_SPARE     = 8'h80
    } init_state_t;

endpackage

// >>> hdl/mr_store.sv
// Small mode register memory with registered read data
`timescale 1ns/100ps
module mr_store #(
    parameter int AW = 4,
    parameter int DW = 8
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Write side
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [DW-1:0] i_wdata,
    // Read side
    input wire logic [AW-1:0] i_raddr,
    output logic [DW-1:0] o_rdata
);
    logic [DW-1:0] mem [2**AW];

    if (AW < 1 || DW < 1) begin : g_bad_size
        $error("AW and DW must be positive");
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            for (int k = 0; k < 2**AW; k++) begin
                mem[k] <= '0;
            end
        end else if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule

// >>> hdl/lpddr_power_up_init.sv
// Device-side power-up, reset and calibration sequencing with data beats
//
// Function
// - Outputs are guaranteed high impedance while clock enable is low.
// - Controller tolerates relaxed boot AC timing before configuration.
// - After reset wait only mode reads and power-down are accepted.
// - Device clears auto-init bit on completion, readable in register zero.
// - Auto-init completes within 10 us of the reset command.
// - Initial calibration may update the resistor connected flag.
// - Device is ready 1 us after initial calibration command.
// - After initialization device is idle and accepts any valid command.
// - One 4n-bit core word leaves as four n-bit beats, two per clock.
// - In idle every bank is precharged.
// - Mode registers are reached only by mode read and mode write.
`timescale 1ns/100ps
`include "lpddr_init_cfg.svh"
module lpddr_power_up_init #(
    parameter int N = 16,
    parameter int NOP_CYC = `T_INIT3_CYC,
    parameter int AUTO_INIT_CYC = `AUTO_INIT_DEF_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Pins from outside
    input wire logic i_supply_ok,
    input wire logic i_cke,
    input wire logic i_zq_pin_connected,
    // Decoded commands
    input wire logic i_cmd_mrw,
    input wire logic i_cmd_mrr,
    input wire logic i_cmd_pre_all,
    input wire logic i_cmd_other,
    input wire logic [7:0] i_ma,
    input wire logic [7:0] i_op,
    // Core data
    input wire logic i_core_valid,
    input wire logic [4*N-1:0] i_core_word,
    output logic o_core_ready,
    // Data pins
    output logic [N-1:0] o_dq_rise,
    output logic [N-1:0] o_dq_fall,
    output logic o_dq_oe_n,
    // Status
    output logic [7:0] o_state,
    output logic o_auto_init_status,
    output logic o_cal_resistor_connected_flag,
    output logic o_ready,
    output logic o_banks_precharged,
    output logic o_cmd_reject,
    output logic o_mrr_valid,
    output logic [7:0] o_mrr_data
);
    localparam int CW = 14;
    localparam int T4 = `T_INIT4_CYC;
    localparam int T5 = `T_INIT5_CYC;
    localparam int ZQC = `T_ZQINIT_CYC;
    localparam logic [CW-1:0] NOP_LAST = CW'(NOP_CYC - 1);
    localparam logic [CW-1:0] T4_LAST = CW'(T4 - 1);
    localparam logic [CW-1:0] AI_LAST = CW'(AUTO_INIT_CYC - 1);
    localparam logic [CW-1:0] ZQ_LAST = CW'(ZQC - 1);

    // Counter width and auto-init window bound what can be served
    if (NOP_CYC < 1 || NOP_CYC >= 2**CW) begin : g_bad_nop
        $error("NOP_CYC out of range");
    end
    if (AUTO_INIT_CYC <= T4 || AUTO_INIT_CYC > T5) begin : g_bad_ai
        $error("AUTO_INIT_CYC out of range");
    end
    if (N < 1) begin : g_bad_n
        $error("N must be positive");
    end

    lpddr_init_pkg::init_state_t state;
    logic [CW-1:0] cnt;
    logic sup_m, sup_s, cke_m, cke_s, zq_m, zq_s;
    logic auto_init_status_bit, cal_resistor_connected_flag;
    logic second;
    logic [2*N-1:0] hold;
    logic mrr_p1, mr0_sel;
    logic [7:0] mr0_val;
    logic [7:0] mem_rdata;

    // Pin inputs cross in through two flops
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sup_m <= 1'b0;
            sup_s <= 1'b0;
            cke_m <= 1'b0;
            cke_s <= 1'b0;
            zq_m <= 1'b0;
            zq_s <= 1'b0;
        end else begin
            sup_m <= i_supply_ok;
            sup_s <= sup_m;
            cke_m <= i_cke;
            cke_s <= cke_m;
            zq_m <= i_zq_pin_connected;
            zq_s <= zq_m;
        end
    end

    // Command acceptance per sequence state
    logic in_idle, rst_cmd, zq_cmd, mrr_ok, mrw_ok, oth_ok, any_cmd;
    logic take;
    always_comb begin
        in_idle = (state == lpddr_init_pkg::ST_IDLE);
        rst_cmd = i_cmd_mrw && i_ma == `MA_RESET && cke_s
                  && state != lpddr_init_pkg::ST_OFF;
        zq_cmd = i_cmd_mrw && in_idle && i_ma == `MA_IMP_CAL
                 && i_op == `OP_ZQ_INIT;
        mrr_ok = i_cmd_mrr && (in_idle
                 || state == lpddr_init_pkg::ST_AUTO_INIT);
        mrw_ok = i_cmd_mrw && in_idle && !rst_cmd;
        oth_ok = (i_cmd_other && in_idle) || (i_cmd_pre_all
                 && (in_idle || state == lpddr_init_pkg::ST_WAIT_RST));
        any_cmd = i_cmd_mrw || i_cmd_mrr || i_cmd_pre_all || i_cmd_other;
        take = i_core_valid && o_core_ready && cke_s && in_idle;
    end

    // Sequence state and interval counter
    always_ff @(posedge i_clk) begin
        if (i_srst || !sup_s) begin
            state <= lpddr_init_pkg::ST_OFF;
            cnt <= '0;
        end else if (rst_cmd) begin
            state <= lpddr_init_pkg::ST_RST_WAIT;
            cnt <= '0;
        end else begin
            case (state)
                lpddr_init_pkg::ST_OFF: begin
                    cnt <= '0;
                    if (cke_s) begin
                        state <= lpddr_init_pkg::ST_NOP;
                    end
                end
                lpddr_init_pkg::ST_NOP: begin
                    cnt <= cnt + 1'b1;
                    if (!cke_s) begin
                        state <= lpddr_init_pkg::ST_OFF;
                    end else if (cnt == NOP_LAST) begin
                        state <= lpddr_init_pkg::ST_WAIT_RST;
                    end
                end
                lpddr_init_pkg::ST_RST_WAIT: begin
                    cnt <= cnt + 1'b1;
                    if (cnt == T4_LAST) begin
                        state <= lpddr_init_pkg::ST_AUTO_INIT;
                    end
                end
                lpddr_init_pkg::ST_AUTO_INIT: begin
                    cnt <= cnt + 1'b1;
                    if (cnt == AI_LAST) begin
                        state <= lpddr_init_pkg::ST_IDLE;
                    end
                end
                lpddr_init_pkg::ST_IDLE: begin
                    cnt <= '0;
                    if (zq_cmd) begin
                        state <= lpddr_init_pkg::ST_ZQ;
                    end
                end
                lpddr_init_pkg::ST_ZQ: begin
                    cnt <= cnt + 1'b1;
                    if (cnt == ZQ_LAST) begin
                        state <= lpddr_init_pkg::ST_IDLE;
                    end
                end
                default: begin
                    cnt <= cnt;
                end
            endcase
        end
    end

    // Auto-init status and calibration resistor flag
    always_ff @(posedge i_clk) begin
        if (i_srst || !sup_s || rst_cmd) begin
            auto_init_status_bit <= `DAI_RST;
        end else if (state == lpddr_init_pkg::ST_AUTO_INIT
                     && cnt == AI_LAST) begin
            auto_init_status_bit <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst || !sup_s) begin
            cal_resistor_connected_flag <= 1'b0;
        end else if (zq_cmd) begin
            cal_resistor_connected_flag <= zq_s;
        end
    end

    // Status outputs lag state by one flop
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_state <= lpddr_init_pkg::ST_OFF;
            o_ready <= 1'b0;
            o_banks_precharged <= 1'b0;
            o_auto_init_status <= `DAI_RST;
            o_cal_resistor_connected_flag <= 1'b0;
            o_cmd_reject <= 1'b0;
        end else begin
            o_state <= state;
            o_ready <= in_idle;
            o_banks_precharged <= in_idle;
            o_auto_init_status <= auto_init_status_bit;
            o_cal_resistor_connected_flag <= cal_resistor_connected_flag;
            o_cmd_reject <= any_cmd && !rst_cmd
                            && !(mrr_ok || mrw_ok || oth_ok);
        end
    end

    // Register zero is built from live status; 1 to 15 sit in memory, higher ones read zero
    mr_store #(.AW(4), .DW(8)) u_mr_store (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_we(mrw_ok && i_ma < 8'(`MR_STORE_DEPTH)
              && i_ma != `MA_DEV_INFO),
        .i_waddr(i_ma[3:0]),
        .i_wdata(i_op),
        .i_raddr(i_ma[3:0]),
        .o_rdata(mem_rdata)
    );

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            mrr_p1 <= 1'b0;
            mr0_sel <= 1'b0;
            mr0_val <= 8'h00;
            o_mrr_valid <= 1'b0;
            o_mrr_data <= 8'h00;
        end else begin
            mrr_p1 <= mrr_ok;
            mr0_sel <= (i_ma == `MA_DEV_INFO) || i_ma >= 8'(`MR_STORE_DEPTH);
            mr0_val <= 8'h00;
            if (i_ma == `MA_DEV_INFO) begin
                mr0_val[`MR0_DAI_BIT] <= auto_init_status_bit;
                mr0_val[`MR0_RZQ_BIT] <= cal_resistor_connected_flag;
            end
            o_mrr_valid <= mrr_p1;
            o_mrr_data <= mrr_p1 ? (mr0_sel ? mr0_val : mem_rdata) : 8'h00;
        end
    end

    // Word to four beats over two clocks; pins idle unless enable is high
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_core_ready <= 1'b0;
            second <= 1'b0;
            hold <= '0;
            o_dq_rise <= '0;
            o_dq_fall <= '0;
            o_dq_oe_n <= 1'b1;
        end else begin
            o_core_ready <= !take;
            second <= take;
            if (take) begin
                o_dq_rise <= i_core_word[N-1:0];
                o_dq_fall <= i_core_word[2*N-1:N];
                hold <= i_core_word[4*N-1:2*N];
            end else if (second) begin
                o_dq_rise <= hold[N-1:0];
                o_dq_fall <= hold[2*N-1:N];
            end
            o_dq_oe_n <= !cke_s || !(take || second);
        end
    end

    // Checks
    property p_hiz_cke_low;
        @(posedge i_clk) disable iff (i_srst)
        !cke_s |=> o_dq_oe_n;
    endproperty
    a_hiz_cke_low: assert property (p_hiz_cke_low)
        else $error("data pins driven while enable low");

    property p_dai_bound;
        @(posedge i_clk) disable iff (i_srst || !sup_s)
        rst_cmd |=> auto_init_status_bit ##[1:T5] !auto_init_status_bit;
    endproperty
    a_dai_bound: assert property (p_dai_bound)
        else $error("auto-init not done in time");

    property p_dai_idle;
        @(posedge i_clk) disable iff (i_srst)
        $fell(auto_init_status_bit) |-> state == lpddr_init_pkg::ST_IDLE ##1 o_ready;
    endproperty
    a_dai_idle: assert property (p_dai_idle)
        else $error("auto-init clear without idle");

    property p_mr0_read;
        @(posedge i_clk) disable iff (i_srst)
        mrr_ok && i_ma == `MA_DEV_INFO |-> ##2 o_mrr_valid
            && o_mrr_data[`MR0_DAI_BIT] == $past(auto_init_status_bit, 2);
    endproperty
    a_mr0_read: assert property (p_mr0_read)
        else $error("status readback wrong");

    property p_zq_ready;
        @(posedge i_clk) disable iff (i_srst || !sup_s)
        zq_cmd && !rst_cmd |=> ##1 !o_ready [*2] ##[1:ZQC] o_ready;
    endproperty
    a_zq_ready: assert property (p_zq_ready)
        else $error("ready timing after calibration wrong");

    property p_idle_precharged;
        @(posedge i_clk) disable iff (i_srst)
        o_ready |-> o_banks_precharged && !o_auto_init_status;
    endproperty
    a_idle_precharged: assert property (p_idle_precharged)
        else $error("idle without banks precharged");

    property p_reject_after_te;
        @(posedge i_clk) disable iff (i_srst)
        state == lpddr_init_pkg::ST_AUTO_INIT && i_cmd_other
            && !rst_cmd |=> o_cmd_reject;
    endproperty
    a_reject_after_te: assert property (p_reject_after_te)
        else $error("command accepted during auto-init");

    property p_beats;
        @(posedge i_clk) disable iff (i_srst)
        take |=> o_dq_rise == $past(i_core_word[N-1:0])
            && !o_dq_oe_n ##1 o_dq_fall == $past(i_core_word[4*N-1:3*N], 2);
    endproperty
    a_beats: assert property (p_beats)
        else $error("beat order wrong");

    property p_restart;
        @(posedge i_clk) disable iff (i_srst || !sup_s)
        rst_cmd |=> state == lpddr_init_pkg::ST_RST_WAIT && cnt == '0;
    endproperty
    a_restart: assert property (p_restart)
        else $error("reset did not restart sequence");
endmodule

// >>> verification/lpddr_ctl_model.sv
// Controller-side model driving supplies, clock enable and commands
`timescale 1ns/100ps
module lpddr_ctl_model (
    // Clock
    input wire logic i_clk,
    // Pins toward the device
    output logic o_supply_ok,
    output logic o_cke,
    output logic o_cmd_mrw,
    output logic o_cmd_mrr,
    output logic o_cmd_pre_all,
    output logic o_cmd_other,
    output logic [7:0] o_ma,
    output logic [7:0] o_op
);
    initial begin
        o_supply_ok = 1'h0;
        o_cke = 1'h0;
        o_cmd_mrw = 1'h0;
        o_cmd_mrr = 1'h0;
        o_cmd_pre_all = 1'h0;
        o_cmd_other = 1'h0;
        o_ma = 8'h00;
        o_op = 8'h00;
    end

    // 20 ns clock stays inside the boot range throughout
    task automatic power_up();
        @(posedge i_clk);
        o_supply_ok <= 1'h1;
        // 100 ns rounds to 5 cycles; one spare covers the stable clocks
        repeat (6) @(posedge i_clk);
        o_cke <= 1'h1;
    endtask

    task automatic set_cke(input logic v);
        @(posedge i_clk);
        o_cke <= v;
    endtask

    // Kind 0 write, 1 read, 2 precharge-all, 3 other; one at a time
    task automatic send(input int kind, input logic [7:0] ma,
                        input logic [7:0] op);
        @(posedge i_clk);
        o_ma <= ma;
        o_op <= op;
        o_cmd_mrw <= (kind == 0);
        o_cmd_mrr <= (kind == 1);
        o_cmd_pre_all <= (kind == 2);
        o_cmd_other <= (kind == 3);
        @(posedge i_clk);
        {o_cmd_mrw, o_cmd_mrr, o_cmd_pre_all, o_cmd_other} <= 4'h0;
        // Released bus shows the inverse, not a stale match
        o_ma <= ~ma;
        o_op <= ~op;
    endtask
endmodule

// >>> verification/lpddr_power_up_init_test.sv
// Self-checking bench for the power-up sequencing block
`timescale 1ns/100ps
`include "lpddr_init_cfg.svh"
module lpddr_power_up_init_test;
    localparam int N = 16;
    localparam int NOP = 20;
    localparam int AI = 100;
    logic i_clk = 1'h0;
    logic i_srst = 1'h1;
    logic i_zq_pin_connected = 1'h0;
    logic i_core_valid = 1'h0;
    logic [4*N-1:0] i_core_word = '0;
    logic supply_ok, cke, mrw, mrr, pre_all, other;
    logic [7:0] ma, op, o_state, o_mrr_data;
    logic o_core_ready, o_dq_oe_n, o_auto_init_status, flag, o_ready;
    logic o_banks_precharged, o_cmd_reject, o_mrr_valid;
    logic [N-1:0] o_dq_rise, o_dq_fall;
    int miscompares = 0;
    int n_checks = 0;
    int cyc = 0;

    always #10 i_clk = ~i_clk;
    always @(posedge i_clk) cyc <= cyc + 1;

    lpddr_ctl_model ctl_u (.i_clk(i_clk), .o_supply_ok(supply_ok),
        .o_cke(cke), .o_cmd_mrw(mrw), .o_cmd_mrr(mrr),
        .o_cmd_pre_all(pre_all), .o_cmd_other(other), .o_ma(ma), .o_op(op));

    lpddr_power_up_init #(.N(N), .NOP_CYC(NOP), .AUTO_INIT_CYC(AI)) dut_u (
        .i_clk(i_clk), .i_srst(i_srst), .i_supply_ok(supply_ok),
        .i_cke(cke), .i_zq_pin_connected(i_zq_pin_connected),
        .i_cmd_mrw(mrw), .i_cmd_mrr(mrr), .i_cmd_pre_all(pre_all),
        .i_cmd_other(other), .i_ma(ma), .i_op(op),
        .i_core_valid(i_core_valid), .i_core_word(i_core_word),
        .o_core_ready(o_core_ready), .o_dq_rise(o_dq_rise),
        .o_dq_fall(o_dq_fall), .o_dq_oe_n(o_dq_oe_n), .o_state(o_state),
        .o_auto_init_status(o_auto_init_status),
        .o_cal_resistor_connected_flag(flag), .o_ready(o_ready),
        .o_banks_precharged(o_banks_precharged),
        .o_cmd_reject(o_cmd_reject), .o_mrr_valid(o_mrr_valid),
        .o_mrr_data(o_mrr_data));

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %0h expected %0h",
                     $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic wait_state(input logic [7:0] s, input int lim,
                              output int n);
        n = 0;
        while (o_state !== s && n < lim) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        check(o_state, s);
    endtask

    // Refusal pulse may land on either of the next two edges
    task automatic cmd(input int kind, input logic [7:0] a,
                       input logic [7:0] d, output logic rej);
        ctl_u.send(kind, a, d);
        #1;
        rej = o_cmd_reject;
        @(posedge i_clk);
        #1;
        rej = rej | o_cmd_reject;
    endtask

    task automatic read_mr(input logic [7:0] a, output logic [7:0] d);
        int n;
        n = 0;
        ctl_u.send(1, a, 8'h00);
        #1;
        while (o_mrr_valid !== 1'h1 && n < 4) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        check(o_mrr_valid, 1'h1);
        d = o_mrr_data;
    endtask

    task automatic wait_ready(input int lim);
        int n;
        n = 0;
        while (o_ready !== 1'h1 && n < lim) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        check(o_ready, 1'h1);
        check(o_banks_precharged, 1'h1);
    endtask

    task automatic t_power_up();
        int n;
        check(o_state, lpddr_init_pkg::ST_OFF);
        check(o_dq_oe_n, 1'h1);
        ctl_u.power_up();
        wait_state(lpddr_init_pkg::ST_NOP, 10, n);
        check(o_dq_oe_n, 1'h1);
        wait_state(lpddr_init_pkg::ST_WAIT_RST, NOP + 10, n);
        check(n >= NOP - 2 && n <= NOP + 2, 1'h1);
    endtask

    task automatic reset_to_idle(input logic with_pre);
        int n;
        int t;
        logic r;
        logic [7:0] d;
        if (with_pre) begin
            cmd(2, 8'h00, 8'h00, r);
            check(r, 1'h0);
        end
        cmd(0, `MA_RESET, 8'h00, r);
        t = cyc;
        check(r, 1'h0);
        wait_state(lpddr_init_pkg::ST_RST_WAIT, 3, n);
        wait_state(lpddr_init_pkg::ST_AUTO_INIT, 60, n);
        check(n >= `T_INIT4_CYC - 4, 1'h1);
        cmd(0, 8'h01, 8'h55, r);
        check(r, 1'h1);
        cmd(3, 8'h00, 8'h00, r);
        check(r, 1'h1);
        read_mr(`MA_DEV_INFO, d);
        check(d[`MR0_DAI_BIT], 1'h1);
        while (d[`MR0_DAI_BIT] === 1'h1 && cyc - t < AI + 20) begin
            read_mr(`MA_DEV_INFO, d);
        end
        check(d[`MR0_DAI_BIT], 1'h0);
        check(cyc - t >= AI - 8 && cyc - t <= AI + 8, 1'h1);
        check(o_auto_init_status, 1'h0);
        wait_ready(4);
    endtask

    task automatic t_zq();
        int t;
        int n;
        logic r;
        logic [7:0] d;
        @(posedge i_clk);
        i_zq_pin_connected <= 1'h1;
        repeat (4) @(posedge i_clk);
        check(flag, 1'h0);
        t = cyc;
        cmd(0, `MA_IMP_CAL, `OP_ZQ_INIT, r);
        check(r, 1'h0);
        wait_state(lpddr_init_pkg::ST_ZQ, 3, n);
        check(o_ready, 1'h0);
        wait_ready(80);
        check(flag, 1'h1);
        check(cyc - t >= `T_ZQINIT_CYC, 1'h1);
        check(cyc - t <= `T_ZQINIT_CYC + 6, 1'h1);
        read_mr(`MA_DEV_INFO, d);
        check(d[`MR0_RZQ_BIT], 1'h1);
    endtask

    task automatic t_mode_regs();
        logic r;
        logic [7:0] d;
        for (int i = 1; i <= 3; i++) begin
            cmd(0, 8'(i), 8'hA0 + 8'(i), r);
            check(r, 1'h0);
            read_mr(8'(i), d);
            check(d, 8'hA0 + 8'(i));
        end
        cmd(3, 8'h00, 8'h00, r);
        check(r, 1'h0);
    endtask

    task automatic t_data();
        logic [4*N-1:0] w;
        int n;
        w = 64'h0123_4567_89AB_CDEF;
        n = 0;
        @(posedge i_clk);
        i_core_valid <= 1'h1;
        i_core_word <= w;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_core_ready !== 1'h1 && n < 10);
        i_core_valid <= 1'h0;
        #1;
        check(o_core_ready, 1'h0);
        check({o_dq_oe_n, o_dq_fall, o_dq_rise}, {1'h0, w[31:0]});
        @(posedge i_clk);
        #1;
        check({o_dq_oe_n, o_dq_fall, o_dq_rise}, {1'h0, w[63:32]});
        @(posedge i_clk);
        #1;
        check(o_dq_oe_n, 1'h1);
        // Enable low: word must stay unclaimed, pins undriven
        ctl_u.set_cke(1'h0);
        repeat (4) @(posedge i_clk);
        i_core_valid <= 1'h1;
        repeat (5) @(posedge i_clk);
        #1;
        check(o_dq_oe_n, 1'h1);
        @(posedge i_clk);
        i_core_valid <= 1'h0;
        ctl_u.set_cke(1'h1);
        repeat (4) @(posedge i_clk);
    endtask

    initial begin
        #(20 * 5000);
        miscompares++;
        results();
    end

    initial begin
        repeat (5) @(posedge i_clk);
        i_srst <= 1'h0;
        @(posedge i_clk);
        #1;
        t_power_up();
        reset_to_idle(1'h1);
        t_zq();
        t_mode_regs();
        t_data();
        reset_to_idle(1'h0);
        results();
    end
endmodule
